/* dv/le_prog_mem.sv */
`timescale 1ns/1ps
module le_prog_mem #(
	parameter int AW = 7
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          rd_i,
	input  wire logic [AW-1:0] addr_i,
	output logic      [15:0]   rdata_o
);
	logic [15:0] mem [2**AW]; // Rows at any word, one word each
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			rdata_o <= 16'h0000;
		else if (rd_i)
			rdata_o <= mem[addr_i]; // Low 11 bits are the output mask
		else
			rdata_o <= ~rdata_o; // Stale data keeps moving
	end
endmodule : le_prog_mem

/* dv/le_ramp_map_properties.sv */
`timescale 1ns/1ps
module le_ramp_map_props #(
	parameter int NUM_OUT = 11
) (
	input wire logic                    sys_clk_i,
	input wire logic                    sys_rst_i,
	input wire logic                    instr_valid_i,
	input wire logic [15:0]             instr_i,
	input wire logic                    busy_o,
	input wire logic                    done_o,
	input wire logic                    mem_rd_o,
	input wire logic [15:0]             mem_rdata_i,
	input wire logic                    host_rd_i,
	input wire logic [7:0]              host_addr_i,
	input wire logic [7:0]              host_rdata_o,
	input wire logic [NUM_OUT-1:0][7:0] host_bright_i,
	input wire logic [NUM_OUT-1:0][7:0] out_bright_o,
	input wire logic [NUM_OUT-1:0]      map_o,
	input wire logic [7:0]              eng_bright_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic       take;
	logic [8:0] opc;
	assign take = instr_valid_i && !busy_o;
	assign opc  = instr_i[15:7];
	property p_sel_one;
		take && opc == 9'h142 && instr_i[3:0] != 4'h0 && instr_i[3:0] <= 4'hB
		|=> map_o == NUM_OUT'(1) << ($past(instr_i[3:0]) - 4'h1);
	endproperty
	a_sel_one: assert property (p_sel_one) else $error("select mask");
	property p_none;
		take && (opc == 9'h143 || (opc == 9'h142 && (instr_i[3:0] == 4'h0 || instr_i[3:0] > 4'hB)))
		|=> map_o == '0;
	endproperty
	a_none: assert property (p_none) else $error("mask not cleared");
	property p_follow;
		map_o == '0 ##1 (map_o == '0 && !$past(sys_rst_i)) |-> out_bright_o == $past(host_bright_i);
	endproperty
	a_follow: assert property (p_follow) else $error("released output");
	property p_fetch;
		mem_rd_o |-> ##2 (done_o && map_o == $past(mem_rdata_i[NUM_OUT-1:0]));
	endproperty
	a_fetch: assert property (p_fetch) else $error("row mask");
	property p_map_bright;
		take && opc >= 9'h140 && opc <= 9'h146 |=> $stable(eng_bright_o) [*3];
	endproperty
	a_map_bright: assert property (p_map_bright) else $error("map moved level");
	property p_step;
		$changed(eng_bright_o) |->
		eng_bright_o == $past(eng_bright_o) + 8'h01 || eng_bright_o == $past(eng_bright_o) - 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("step size");
	property p_fast;
		take && instr_i[15:10] == 6'h22 |=> done_o && !busy_o ##1 $stable(eng_bright_o);
	endproperty
	a_fast: assert property (p_fast) else $error("fast ramp ran");
	property p_rd_other;
		host_rd_i && host_addr_i != 8'h3C |=> host_rdata_o == 8'h00;
	endproperty
	a_rd_other: assert property (p_rd_other) else $error("read other");
	property p_ramp_busy;
		take && instr_i[15:10] == 6'h21 |=> busy_o [*8];
	endproperty
	a_ramp_busy: assert property (p_ramp_busy) else $error("ramp too short");
	c_fetch: cover property (mem_rd_o);
	c_step: cover property ($changed(eng_bright_o));
	c_fast: cover property (take && instr_i[15:10] == 6'h22);
endmodule : le_ramp_map_props

/* dv/le_ramp_map_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((e) !== (a)) begin errors++; \
	$display("unexpected %s expected %h seen %h", n, e, a); end end
module le_ramp_map_tb;
	logic             sys_clk_i, sys_rst_i, mclk_i, instr_valid_i, host_wr_i, host_rd_i;
	logic             adc_src_i, busy_o, done_o, mem_rd_o;
	logic [15:0]      instr_i, mem_rdata_i, row[3];
	logic [6:0]       mem_addr_o;
	logic [7:0]       host_addr_i, host_wdata_i, host_rdata_o, adc_result_i, eng_bright_o, cur_eng;
	logic [10:0]      map_o, cur_map;
	logic [10:0][7:0] host_bright_i, out_bright_o;
	logic [31:0]      seed;
	logic [18:0]      exp_q[$];
	int               errors, check_count, n;
	localparam logic [2:0] KOP [6] = '{3'h6, 3'h4, 3'h4, 3'h4, 3'h5, 3'h6};
	localparam int         RIX [6] = '{0, 1, 2, 0, 2, 1};
	le_ramp_map i_le_ramp_map (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .mclk_i(mclk_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i), .busy_o(busy_o), .done_o(done_o),
		.mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i),
		.host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_addr_i(host_addr_i),
		.host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o), .adc_src_i(adc_src_i),
		.adc_result_i(adc_result_i), .host_bright_i(host_bright_i),
		.out_bright_o(out_bright_o), .map_o(map_o), .eng_bright_o(eng_bright_o));
	le_prog_mem i_le_prog_mem (.clk_i(sys_clk_i), .rst_i(sys_rst_i), .rd_i(mem_rd_o),
		.addr_i(mem_addr_o), .rdata_o(mem_rdata_i));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [15:0] mop(input logic [2:0] k, input logic [6:0] a);
		return {6'h28, k, a};
	endfunction : mop
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	task automatic op(input logic [15:0] w);
		@(posedge sys_clk_i);
		instr_valid_i <= 1'b1;
		instr_i <= w;
		exp_q.push_back({cur_map, cur_eng});
		n = 0;
		@(posedge sys_clk_i);
		instr_valid_i <= 1'b0;
		while (done_o !== 1'b1 && n < 20000) begin
			@(posedge sys_clk_i);
			n++;
		end
		`CHK("instruction done", 1'b1, done_o)
	endtask : op
	task automatic ramp(input logic [5:0] f, input int edges, input logic [7:0] fin);
		cur_eng = fin;
		op({6'h21, 4'h0, f});
		`CHK("ramp span", 1'b1, n > (edges - 1) * 20 && n <= edges * 20 + 20)
		`CHK("mapped out", fin, out_bright_o[0])
	endtask : ramp
	task automatic host(input logic wr, input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		host_wr_i <= wr;
		host_rd_i <= !wr;
		host_addr_i <= a;
		host_wdata_i <= v;
		@(posedge sys_clk_i);
		host_wr_i <= 1'b0;
		host_rd_i <= 1'b0;
		#1;
		if (!wr) `CHK("host read", v, host_rdata_o)
	endtask : host
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		mclk_i = 1'b0;
		forever #100 mclk_i = ~mclk_i;
	end
	always @(posedge sys_clk_i) begin
		if (done_o === 1'b1 && exp_q.size() > 0) begin
			`CHK("map", exp_q[0][18:8], map_o)
			`CHK("engine level", exp_q[0][7:0], eng_bright_o)
			void'(exp_q.pop_front());
		end
	end
	initial begin
		repeat (40000) @(posedge sys_clk_i);
		errors++;
		report_and_stop();
	end
	initial begin
		{sys_rst_i, instr_valid_i, host_wr_i, host_rd_i, adc_src_i} = 5'h10;
		{instr_i, host_addr_i, host_wdata_i, adc_result_i, cur_map, cur_eng} = '0;
		errors = 0;
		check_count = 0;
		seed = 32'hB744;
		for (int i = 0; i < 11; i++) begin
			seed = lfsr(seed);
			host_bright_i[i] = seed[7:0];
		end
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(lfsr(lfsr(seed)));
			row[i] = seed[15:0];
			i_le_prog_mem.mem[20 + i] = row[i];
		end
		repeat (12) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		host(1'b0, 8'h3C, 8'h00);
		host(1'b1, 8'h3C, 8'h05);
		host(1'b0, 8'h3C, 8'h05);
		host(1'b0, 8'h3D, 8'h00);
		$display("host variable test done");
		for (int c = 0; c < 13; c++) begin
			cur_map = (c > 0 && c < 12) ? 11'h001 << (c - 1) : 11'h000;
			op(mop(3'h2, 7'(c)));
		end
		cur_map = 11'h000;
		op(mop(3'h3, 7'h00));
		host_bright_i[3] <= ~host_bright_i[3];
		repeat (2) @(posedge sys_clk_i);
		#1;
		`CHK("released out", host_bright_i, out_bright_o)
		$display("select and clear test done");
		op(mop(3'h0, 7'h14));
		op(mop(3'h1, 7'h16));
		for (int i = 0; i < 6; i++) begin
			cur_map = row[RIX[i]][10:0];
			op(mop(KOP[i], 7'(RIX[i])));
		end
		$display("row table test done");
		cur_map = 11'h001;
		op(mop(3'h2, 7'h01));
		op({4'h9, 2'h0, 2'h0, 8'h02});
		op({4'h9, 2'h1, 2'h0, 8'h03});
		op({4'h9, 2'h2, 2'h0, 8'h00});
		ramp(6'h01, 96, 8'h03);
		host(1'b1, 8'h3C, 8'h05);
		op({4'h9, 2'h3, 2'h0, 8'h1F});
		fork
			ramp(6'h03, 160, 8'h08);
			begin
				repeat (300) @(posedge sys_clk_i);
				host(1'b1, 8'h3C, 8'h00);
			end
		join
		ramp(6'h19, 48, 8'h08);
		ramp(6'h12, 32, 8'h08);
		op({4'h9, 2'h1, 2'h0, 8'h02});
		ramp(6'h11, 64, 8'h06);
		adc_src_i <= 1'b1;
		adc_result_i <= 8'h01;
		ramp(6'h2F, 512, 8'h07);
		$display("variable ramp test done");
		op({6'h22, 10'h011});
		$display("fast ramp test done");
		report_and_stop();
	end
endmodule : le_ramp_map_tb
bind le_ramp_map le_ramp_map_props #(.NUM_OUT(NUM_OUT)) i_le_ramp_map_props (
	.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
	.instr_i(instr_i), .busy_o(busy_o), .done_o(done_o), .mem_rd_o(mem_rd_o),
	.mem_rdata_i(mem_rdata_i), .host_rd_i(host_rd_i), .host_addr_i(host_addr_i),
	.host_rdata_o(host_rdata_o), .host_bright_i(host_bright_i),
	.out_bright_o(out_bright_o), .map_o(map_o), .eng_bright_o(eng_bright_o));

/* rtl/le_map_consts.svh */
// Contract
// - Ramp latches variable operands at start
// - Each step moves mapped brightness at most one unit
// - Operand selector: A, B, C, D order
// - A-C by instruction; D host/converter sourced
// - Step duration is step time times prescale; step time 0 counts as 1
// - Fast ramp has no variable form
// - Mapping table anywhere, one word per row
// - Row bits 0-9 LEDs, bit 10 haptic
// - Several mask bits map several outputs
// - Mapping never changes brightness by itself
// - Table first and last address stored
// - Single select: 0 none, 1-10 LED, 11 haptic
// - Clear mapping returns outputs to host value
// - Next row wraps end to start
// - Previous row wraps start to end
// - Set row loads index from bits 6:0
// - Prescale divides master clock 16 or 512
// - Saturated ramp still runs all steps
`ifndef LE_MAP_CONSTS_SVH
`define LE_MAP_CONSTS_SVH
`define VAR_D_OFFSET    8'h3C
`define VAR_D_RESET     8'h00
`define OPC_LD          4'h9
`define LD_SUBOP        2'h0
`define OPC_RAMP_VAR    6'h21
`define OPC_FAST_VAR    6'h22
`define MAP_TABLE_FIRST_ADDR_CMD 9'h140
`define MAP_TABLE_LAST_ADDR_CMD  9'h141
`define OPC_MAP_SEL     9'h142
`define OPC_MAP_CLR     9'h143
`define OPC_MAP_NEXT    9'h144
`define OPC_MAP_PREV    9'h145
`define OPC_MAP_SET     9'h146
`define SEL_CODE_MAX    4'hB
`define PRESC_DIV0      9'h00F
`define PRESC_DIV1      9'h1FF
`define BRIGHT_MAX      8'hFF
`define BRIGHT_MIN      8'h00
`endif

/* rtl/le_map_pkg.sv */
package le_map_pkg;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_FETCH = 4'b0010,
		ST_APPLY = 4'b0100,
		ST_RAMP  = 4'b1000
	} eng_state_type;
	typedef enum logic [1:0] {
		VAR_A = 2'h0,
		VAR_B = 2'h1,
		VAR_C = 2'h2,
		VAR_D = 2'h3
	} var_sel_type;
endpackage : le_map_pkg

/* rtl/le_ramp_map.sv */
`timescale 1ns/1ps
`include "le_map_consts.svh"

module le_ramp_map
	import le_map_pkg::*;
#(
	parameter int NUM_OUT = 11,
	parameter int AW      = 7
) (
	input  wire logic                    sys_clk_i,
	input  wire logic                    sys_rst_i,
	input  wire logic                    mclk_i,
	input  wire logic                    instr_valid_i,
	input  wire logic [15:0]             instr_i,
	output logic                         busy_o,
	output logic                         done_o,
	output logic                         mem_rd_o,
	output logic [AW-1:0]                mem_addr_o,
	input  wire logic [15:0]             mem_rdata_i,
	input  wire logic                    host_wr_i,
	input  wire logic                    host_rd_i,
	input  wire logic [7:0]              host_addr_i,
	input  wire logic [7:0]              host_wdata_i,
	output logic [7:0]                   host_rdata_o,
	input  wire logic                    adc_src_i,
	input  wire logic [7:0]              adc_result_i,
	input  wire logic [NUM_OUT-1:0][7:0] host_bright_i,
	output logic [NUM_OUT-1:0][7:0]      out_bright_o,
	output logic [NUM_OUT-1:0]           map_o,
	output logic [7:0]                   eng_bright_o
);

	// Master clock synchroniser; stage 1 feeds only stage 2
	logic       mclk_s1_reg;
	logic       mclk_s2_reg;
	logic       mclk_s3_reg;
	logic       mclk_filt_reg;
	logic       mclk_filt_next;
	logic       mclk_edge;

	always_comb begin
		mclk_filt_next = mclk_filt_reg;
		if (mclk_s2_reg == mclk_s3_reg) begin
			mclk_filt_next = mclk_s3_reg;
		end
		mclk_edge = mclk_filt_next & ~mclk_filt_reg;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mclk_s1_reg   <= 1'b0;
			mclk_s2_reg   <= 1'b0;
			mclk_s3_reg   <= 1'b0;
			mclk_filt_reg <= 1'b0;
		end else begin
			mclk_s1_reg   <= mclk_i;
			mclk_s2_reg   <= mclk_s1_reg;
			mclk_s3_reg   <= mclk_s2_reg;
			mclk_filt_reg <= mclk_filt_next;
		end
	end

	// Host variable register
	logic [7:0] var_d_reg;
	logic [7:0] var_d_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [7:0] var_d_val;

	always_comb begin
		var_d_next = var_d_reg;
		rdata_next = rdata_reg;
		if (host_wr_i && host_addr_i == `VAR_D_OFFSET) begin
			var_d_next = host_wdata_i;
		end
		if (host_rd_i) begin
			rdata_next = (host_addr_i == `VAR_D_OFFSET) ? var_d_reg : 8'h00;
		end
		var_d_val = adc_src_i ? adc_result_i : var_d_reg;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			var_d_reg <= `VAR_D_RESET;
			rdata_reg <= 8'h00;
		end else begin
			var_d_reg <= var_d_next;
			rdata_reg <= rdata_next;
		end
	end

	assign host_rdata_o = rdata_reg;

	// Engine state
	eng_state_type      state_reg;
	eng_state_type      state_next;
	logic [7:0]         var_a_reg;
	logic [7:0]         var_a_next;
	logic [7:0]         var_b_reg;
	logic [7:0]         var_b_next;
	logic [7:0]         var_c_reg;
	logic [7:0]         var_c_next;
	logic [AW-1:0]      first_reg;
	logic [AW-1:0]      first_next;
	logic [AW-1:0]      last_reg;
	logic [AW-1:0]      last_next;
	logic [AW-1:0]      row_reg;
	logic [AW-1:0]      row_next;
	logic [NUM_OUT-1:0] map_reg;
	logic [NUM_OUT-1:0] map_next;
	logic [7:0]         bright_reg;
	logic [7:0]         bright_next;
	logic [4:0]         step_reg;
	logic [4:0]         step_next;
	logic [7:0]         steps_left_reg;
	logic [7:0]         steps_left_next;
	logic               change_reg;
	logic               change_next;
	logic               presc_reg;
	logic               presc_next;
	logic               dir_down_reg;
	logic               dir_down_next;
	logic [8:0]         unit_cnt_reg;
	logic [8:0]         unit_cnt_next;
	logic [4:0]         step_cnt_reg;
	logic [4:0]         step_cnt_next;
	logic               busy_reg;
	logic               busy_next;
	logic               done_reg;
	logic               done_next;
	logic               rd_reg;
	logic               rd_next;
	logic               push_next;
	logic [8:0]         div_last;
	logic [4:0]         step_span;
	logic [7:0]         sel_step_val;
	logic [7:0]         sel_inc_val;
	logic [3:0]         sel_code;

	function automatic logic [7:0] pick_var(
		input logic [1:0] sel,
		input logic [7:0] a,
		input logic [7:0] b,
		input logic [7:0] c,
		input logic [7:0] d
	);
		logic [7:0] v;
		v = a;
		unique case (var_sel_type'(sel))
			VAR_A: v = a;
			VAR_B: v = b;
			VAR_C: v = c;
			VAR_D: v = d;
		endcase
		return v;
	endfunction : pick_var

	always_comb begin
		state_next      = state_reg;
		var_a_next      = var_a_reg;
		var_b_next      = var_b_reg;
		var_c_next      = var_c_reg;
		first_next      = first_reg;
		last_next       = last_reg;
		row_next        = row_reg;
		map_next        = map_reg;
		bright_next     = bright_reg;
		step_next       = step_reg;
		steps_left_next = steps_left_reg;
		change_next     = change_reg;
		presc_next      = presc_reg;
		dir_down_next   = dir_down_reg;
		unit_cnt_next   = unit_cnt_reg;
		step_cnt_next   = step_cnt_reg;
		busy_next       = busy_reg;
		done_next       = 1'b0;
		rd_next         = 1'b0;
		push_next       = 1'b0;
		sel_step_val    = pick_var(instr_i[3:2], var_a_reg, var_b_reg, var_c_reg, var_d_val);
		sel_inc_val     = pick_var(instr_i[1:0], var_a_reg, var_b_reg, var_c_reg, var_d_val);
		sel_code        = instr_i[3:0];
		div_last        = presc_reg ? `PRESC_DIV1 : `PRESC_DIV0;
		step_span       = (step_reg == 5'h00) ? 5'h01 : step_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (instr_valid_i) begin
					busy_next = 1'b1;
					done_next = 1'b1;
					busy_next = 1'b0;
					if (instr_i[15:12] == `OPC_LD && instr_i[9:8] == `LD_SUBOP) begin
						unique case (var_sel_type'(instr_i[11:10]))
							VAR_A: var_a_next = instr_i[7:0];
							VAR_B: var_b_next = instr_i[7:0];
							VAR_C: var_c_next = instr_i[7:0];
							VAR_D: var_a_next = var_a_reg;
						endcase
					end else if (instr_i[15:10] == `OPC_RAMP_VAR) begin
						// Operands frozen here; later variable writes are not seen
						step_next       = sel_step_val[4:0];
						steps_left_next = (sel_inc_val == 8'h00) ? 8'h01 : sel_inc_val;
						change_next     = (sel_step_val[4:0] != 5'h00) &&
						                  (sel_inc_val != 8'h00);
						presc_next      = instr_i[5];
						dir_down_next   = instr_i[4];
						unit_cnt_next   = 9'h000;
						step_cnt_next   = 5'h00;
						done_next       = 1'b0;
						busy_next       = 1'b1;
						state_next      = ST_RAMP;
					end else if (instr_i[15:10] == `OPC_FAST_VAR) begin
						// No variable form of the fast ramp: finishes with no effect
						done_next = 1'b1;
					end else begin
						unique case (instr_i[15:7])
							`MAP_TABLE_FIRST_ADDR_CMD: first_next = instr_i[AW-1:0];
							`MAP_TABLE_LAST_ADDR_CMD:  last_next = instr_i[AW-1:0];
							`OPC_MAP_SEL: begin
								map_next = '0;
								if (sel_code != 4'h0 && sel_code <= `SEL_CODE_MAX) begin
									map_next[sel_code - 4'h1] = 1'b1;
								end
							end
							`OPC_MAP_CLR:   map_next = '0;
							`OPC_MAP_NEXT: begin
								row_next = (row_reg == last_reg) ? first_reg :
								           AW'(row_reg + 1'b1);
							end
							`OPC_MAP_PREV: begin
								row_next = (row_reg == first_reg) ? last_reg :
								           AW'(row_reg - 1'b1);
							end
							`OPC_MAP_SET:   row_next = AW'(first_reg + instr_i[6:0]);
							default:        row_next = row_reg;
						endcase
						if (instr_i[15:7] == `OPC_MAP_NEXT || instr_i[15:7] == `OPC_MAP_PREV ||
						    instr_i[15:7] == `OPC_MAP_SET) begin
							rd_next    = 1'b1;
							done_next  = 1'b0;
							busy_next  = 1'b1;
							state_next = ST_FETCH;
						end
					end
				end
			end
			ST_FETCH: begin
				state_next = ST_APPLY;
			end
			ST_APPLY: begin
				// Row read back; brightness is not pushed here
				map_next   = mem_rdata_i[NUM_OUT-1:0];
				done_next  = 1'b1;
				busy_next  = 1'b0;
				state_next = ST_IDLE;
			end
			ST_RAMP: begin
				if (mclk_edge) begin
					if (unit_cnt_reg == div_last) begin
						unit_cnt_next = 9'h000;
						if (step_cnt_reg == step_span - 5'h01) begin
							step_cnt_next = 5'h00;
							if (change_reg) begin
								push_next = 1'b1;
								if (dir_down_reg && bright_reg != `BRIGHT_MIN) begin
									bright_next = bright_reg - 8'h01;
								end else if (!dir_down_reg && bright_reg != `BRIGHT_MAX) begin
									bright_next = bright_reg + 8'h01;
								end
							end
							// Saturation does not cut the step count short
							steps_left_next = steps_left_reg - 8'h01;
							if (steps_left_reg == 8'h01) begin
								done_next  = 1'b1;
								busy_next  = 1'b0;
								state_next = ST_IDLE;
							end
						end else begin
							step_cnt_next = step_cnt_reg + 5'h01;
						end
					end else begin
						unit_cnt_next = unit_cnt_reg + 9'h001;
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg      <= ST_IDLE;
			var_a_reg      <= 8'h00;
			var_b_reg      <= 8'h00;
			var_c_reg      <= 8'h00;
			first_reg      <= '0;
			last_reg       <= '0;
			row_reg        <= '0;
			map_reg        <= '0;
			bright_reg     <= 8'h00;
			step_reg       <= 5'h00;
			steps_left_reg <= 8'h00;
			change_reg     <= 1'b0;
			presc_reg      <= 1'b0;
			dir_down_reg   <= 1'b0;
			unit_cnt_reg   <= 9'h000;
			step_cnt_reg   <= 5'h00;
			busy_reg       <= 1'b0;
			done_reg       <= 1'b0;
			rd_reg         <= 1'b0;
		end else begin
			state_reg      <= state_next;
			var_a_reg      <= var_a_next;
			var_b_reg      <= var_b_next;
			var_c_reg      <= var_c_next;
			first_reg      <= first_next;
			last_reg       <= last_next;
			row_reg        <= row_next;
			map_reg        <= map_next;
			bright_reg     <= bright_next;
			step_reg       <= step_next;
			steps_left_reg <= steps_left_next;
			change_reg     <= change_next;
			presc_reg      <= presc_next;
			dir_down_reg   <= dir_down_next;
			unit_cnt_reg   <= unit_cnt_next;
			step_cnt_reg   <= step_cnt_next;
			busy_reg       <= busy_next;
			done_reg       <= done_next;
			rd_reg         <= rd_next;
		end
	end

	assign busy_o       = busy_reg;
	assign done_o       = done_reg;
	assign mem_rd_o     = rd_reg;
	assign mem_addr_o   = row_reg;
	assign map_o        = map_reg;
	assign eng_bright_o = bright_reg;

	// Per-output brightness: mapped outputs hold until a ramp step pushes
	logic [NUM_OUT-1:0][7:0] out_reg;
	logic [NUM_OUT-1:0][7:0] out_next;

	for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
		always_comb begin
			out_next[i] = out_reg[i];
			if (!map_reg[i]) begin
				out_next[i] = host_bright_i[i];
			end else if (push_next) begin
				out_next[i] = bright_next;
			end
		end

		always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
			if (sys_rst_i) begin
				out_reg[i] <= 8'h00;
			end else begin
				out_reg[i] <= out_next[i];
			end
		end
	end

	assign out_bright_o = out_reg;

endmodule : le_ramp_map
